// *** rtl/srp_top.sv ***
// Security-register erase/program command logic of a serial flash.
// Assumes serial pins already synchronous to CLOCK, sampled much faster than SCLK.
`timescale 1ns/10ps
`default_nettype none
`include "srp_defs.svh"

module srp_top #(
  parameter int ERASE_CYCLES = `SRP_ERASE_TIME_NS / `SRP_CLK_PERIOD_NS,
  parameter int PROG_CYCLES = `SRP_PROG_TIME_NS / `SRP_CLK_PERIOD_NS
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic [2:0] LOCK_SET,
  input wire logic [9:0] MEM_RD_ADDR,
  output logic SERIAL_DATA_OUT,
  output logic BUSY,
  output logic WRITE_ENABLE_LATCH,
  output logic [2:0] SECURITY_LOCK_BITS,
  output logic [7:0] MEM_RD_DATA
);

  // ----------------------------------------
  // Pin edges
  // ----------------------------------------
  logic sclk_d_r;
  logic cs_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= SCLK;
      cs_d_r <= CS_N;
    end
  end

  assign sclk_rise = SCLK && !sclk_d_r && !CS_N;
  assign sclk_fall = !SCLK && sclk_d_r && !CS_N;
  assign cs_rise = CS_N && !cs_d_r;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  srp_pkg::srp_state_type state_r;
  logic [7:0] shift_r;
  logic [2:0] bitcnt_r;
  logic [1:0] addrcnt_r;
  logic [23:0] addr_r;
  logic [7:0] ptr_r;
  logic [5:0] frame_bits_r;
  logic is_erase_r;
  logic data_seen_r;
  logic status_sel_r;
  logic [7:0] byte_in;
  logic byte_done;
  logic busy_r;
  logic wel_r;
  logic [2:0] lock_r;
  logic addr_ok;
  logic [1:0] bank;
  logic locked;
  logic cmd_ok;
  logic push_valid;
  logic push_ready;

  assign byte_in = {shift_r[6:0], SERIAL_DATA_IN};
  assign byte_done = sclk_rise && (bitcnt_r == `SRP_BYTE_LAST);

  assign addr_ok = (addr_r[23:16] == `SRP_ADDR_HI_ZERO)
    && (addr_r[11:8] == `SRP_ADDR_MID_ZERO)
    && (addr_r[15:12] >= `SRP_BANK_FIRST) && (addr_r[15:12] <= `SRP_BANK_LAST);
  assign bank = addr_r[13:12] - 2'h1;
  assign locked = lock_r[bank];
  assign cmd_ok = addr_ok && !locked && wel_r;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      state_r <= srp_pkg::ST_OPCODE;
      shift_r <= 8'h00;
      bitcnt_r <= 3'h0;
      addrcnt_r <= 2'h0;
      addr_r <= 24'h000000;
      ptr_r <= 8'h00;
      frame_bits_r <= 6'h00;
      is_erase_r <= 1'b0;
      data_seen_r <= 1'b0;
      status_sel_r <= 1'b0;
    end
    else if (CS_N)
    begin
      // Chip select high ends any frame
      state_r <= srp_pkg::ST_OPCODE;
      bitcnt_r <= 3'h0;
      addrcnt_r <= 2'h0;
      frame_bits_r <= 6'h00;
      data_seen_r <= 1'b0;
    end
    else if (sclk_rise)
    begin
      shift_r <= byte_in;
      bitcnt_r <= bitcnt_r + 3'h1;
      if (frame_bits_r != `SRP_FRAME_BITS_MAX)
        frame_bits_r <= frame_bits_r + 6'h01;
      if (byte_done)
      begin
        case (state_r)
          srp_pkg::ST_OPCODE:
          begin
            if (byte_in == `SRP_OP_RDSR1 || byte_in == `SRP_OP_RDSR2)
            begin
              state_r <= srp_pkg::ST_STATUS;
              status_sel_r <= (byte_in == `SRP_OP_RDSR2);
            end
            else if (busy_r)
              state_r <= srp_pkg::ST_IGNORE;
            else if (byte_in == `SRP_OP_ERASE || byte_in == `SRP_OP_PROG)
            begin
              state_r <= srp_pkg::ST_ADDR;
              is_erase_r <= (byte_in == `SRP_OP_ERASE);
            end
            else
              state_r <= srp_pkg::ST_IGNORE;
          end
          srp_pkg::ST_ADDR:
          begin
            addr_r <= {addr_r[15:0], byte_in};
            addrcnt_r <= addrcnt_r + 2'h1;
            if (addrcnt_r == `SRP_ADDR_BYTES_LAST)
            begin
              state_r <= srp_pkg::ST_DATA;
              ptr_r <= byte_in;
            end
          end
          srp_pkg::ST_DATA:
          begin
            data_seen_r <= 1'b1;
            ptr_r <= ptr_r + 8'h01;
          end
          srp_pkg::ST_STATUS:
            state_r <= srp_pkg::ST_STATUS;
          srp_pkg::ST_IGNORE:
            state_r <= srp_pkg::ST_IGNORE;
          default:
            state_r <= srp_pkg::ST_IGNORE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Program data path
  // ----------------------------------------
  srp_pkg::srp_wr_type push_word;
  srp_pkg::srp_wr_type pop_word;
  logic pop_valid;
  logic pop_ready;
  logic erase_go;
  logic [1:0] erase_bank_r;

  // Lock and latch checked per byte; a stall of the array never drops one
  assign push_valid = byte_done && (state_r == srp_pkg::ST_DATA) && !is_erase_r
    && cmd_ok;
  assign push_word = '{bank: bank, ptr: ptr_r, data: byte_in};
  assign pop_ready = !erase_go;

  srp_buf2 #(
    .W($bits(srp_pkg::srp_wr_type))
  ) u_buf (
    .clk(CLOCK),
    .rst(RESET),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_word)
  );

  // ----------------------------------------
  // Security register array (not reset: nonvolatile)
  // ----------------------------------------
  logic [7:0] mem [3 * `SRP_BANK_BYTES];

  always_ff @(posedge CLOCK)
  begin
    if (erase_go)
    begin
      for (int i = 0; i < `SRP_BANK_BYTES; i++)
        mem[{erase_bank_r, 8'(i)}] <= `SRP_ERASED;
    end
    else if (pop_valid)
      mem[{pop_word.bank, pop_word.ptr}] <= mem[{pop_word.bank, pop_word.ptr}]
        & pop_word.data;
    MEM_RD_DATA <= mem[MEM_RD_ADDR];
  end

  // ----------------------------------------
  // Self-timed cycle
  // ----------------------------------------
  logic [31:0] timer_r;
  logic erase_start;
  logic prog_start;

  assign erase_start = cs_rise && state_r == srp_pkg::ST_DATA && is_erase_r
    && frame_bits_r == `SRP_ERASE_FRAME_BITS && bitcnt_r == 3'h0 && cmd_ok;
  assign prog_start = cs_rise && state_r == srp_pkg::ST_DATA && !is_erase_r
    && data_seen_r && cmd_ok;
  assign erase_go = busy_r && is_erase_r && (timer_r == 32'h0);

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      busy_r <= 1'b0;
      timer_r <= 32'h0;
      erase_bank_r <= 2'h0;
    end
    else if (erase_start || prog_start)
    begin
      busy_r <= 1'b1;
      timer_r <= erase_start ? 32'(ERASE_CYCLES - 1) : 32'(PROG_CYCLES - 1);
      erase_bank_r <= bank;
    end
    else if (busy_r)
    begin
      if (timer_r == 32'h0)
        busy_r <= 1'b0;
      else
        timer_r <= timer_r - 32'h1;
    end
  end

  // ----------------------------------------
  // Write enable latch and lock bits
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      wel_r <= 1'b0;
    else if (busy_r && timer_r == 32'h0)
      wel_r <= 1'b0;
    else if (byte_done && state_r == srp_pkg::ST_OPCODE && !busy_r)
    begin
      if (byte_in == `SRP_OP_WREN)
        wel_r <= 1'b1;
      else if (byte_in == `SRP_OP_WRDI)
        wel_r <= 1'b0;
    end
  end

  // One-time: bits only set; only reset clears them
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      lock_r <= 3'h0;
    else
      lock_r <= lock_r | LOCK_SET;
  end

  // ----------------------------------------
  // Status output, reloaded live every byte
  // ----------------------------------------
  logic [7:0] status_byte;
  logic [7:0] out_sh_r;
  logic so_r;

  always_comb
  begin
    status_byte = 8'h00;
    if (status_sel_r)
      status_byte[`SRP_ST_LOCK_HI:`SRP_ST_LOCK_LO] = lock_r;
    else
    begin
      status_byte[`SRP_ST_BUSY] = busy_r;
      status_byte[`SRP_ST_WEL] = wel_r;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      out_sh_r <= 8'h00;
      so_r <= 1'b0;
    end
    else if (sclk_fall && state_r == srp_pkg::ST_STATUS)
    begin
      if (bitcnt_r == 3'h0)
      begin
        so_r <= status_byte[7];
        out_sh_r <= {status_byte[6:0], 1'b0};
      end
      else
      begin
        so_r <= out_sh_r[7];
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end

  assign SERIAL_DATA_OUT = so_r;
  assign BUSY = busy_r;
  assign WRITE_ENABLE_LATCH = wel_r;
  assign SECURITY_LOCK_BITS = lock_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  logic [31:0] busy_len_r;
  logic kind_erase_r;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      busy_len_r <= 32'h0;
      kind_erase_r <= 1'b0;
    end
    else
    begin
      busy_len_r <= busy_r ? busy_len_r + 32'h1 : 32'h0;
      if (erase_start || prog_start)
        kind_erase_r <= erase_start;
    end
  end

  a_erase_needs_wel: assert property ($rose(busy_r) |-> $past(wel_r))
    else $error("cycle started without write enable latch");
  a_erase_addr_ok: assert property ($rose(busy_r) |-> $past(addr_ok) && !$past(locked))
    else $error("cycle started on bad or locked address");
  a_erase_frame_len: assert property (
    $rose(busy_r) && kind_erase_r |-> $past(frame_bits_r) == `SRP_ERASE_FRAME_BITS)
    else $error("erase started on wrong frame length");
  // Counter already holds the full spell on the edge that sees busy low
  a_busy_len: assert property (
    $fell(busy_r) |-> busy_len_r == (kind_erase_r ? ERASE_CYCLES : PROG_CYCLES))
    else $error("busy length wrong");
  a_wel_cleared: assert property ($fell(busy_r) |-> !wel_r)
    else $error("write enable latch not cleared after cycle");
  a_lock_sticky: assert property (($past(lock_r) & ~lock_r) == 3'h0)
    else $error("lock bit cleared");
  a_prog_gated: assert property (push_valid |-> wel_r && !locked && !busy_r)
    else $error("program byte accepted while not allowed");
  a_erase_fills: assert property (
    erase_go |=> mem[{erase_bank_r, 8'h00}] == `SRP_ERASED
    && mem[{erase_bank_r, 8'hff}] == `SRP_ERASED)
    else $error("erase did not set bytes to erased value");
  // Last busy cycle left out: the latch clears there by design
  a_busy_ignores: assert property (
    busy_r && timer_r != 32'h0 && byte_done && state_r == srp_pkg::ST_OPCODE
    && byte_in != `SRP_OP_RDSR1 && byte_in != `SRP_OP_RDSR2
    |=> state_r == srp_pkg::ST_IGNORE && $stable(wel_r))
    else $error("command acted on while busy");

  c_erase_done: cover property (kind_erase_r && $fell(busy_r));
  c_prog_done: cover property (!kind_erase_r && $fell(busy_r));
  c_poll_busy: cover property (busy_r && state_r == srp_pkg::ST_STATUS && sclk_fall);

endmodule // srp_top

`default_nettype wire

// *** rtl/srp_defs.svh ***
// Constants of the security-register erase/program command logic.
// Assumes a 100 MHz system clock sampling the serial pins.
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SRP_OP_WREN 8'h06
`define SRP_OP_WRDI 8'h04
`define SRP_OP_RDSR1 8'h05
`define SRP_OP_RDSR2 8'h35
`define SRP_OP_ERASE 8'h44
`define SRP_OP_PROG 8'h42

// ----------------------------------------
// Address layout and frame length
// ----------------------------------------
`define SRP_ADDR_HI_ZERO 8'h00
`define SRP_ADDR_MID_ZERO 4'h0
`define SRP_BANK_FIRST 4'h1
`define SRP_BANK_LAST 4'h3
`define SRP_ERASE_FRAME_BITS 6'h20
`define SRP_FRAME_BITS_MAX 6'h3f
`define SRP_BYTE_LAST 3'h7
`define SRP_ADDR_BYTES_LAST 2'h2
`define SRP_ERASED 8'hff
`define SRP_BANK_BYTES 256

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define SRP_ST_BUSY 0
`define SRP_ST_WEL 1
`define SRP_ST_LOCK_LO 3
`define SRP_ST_LOCK_HI 5

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRP_CLK_PERIOD_NS 10
`define SRP_ERASE_TIME_NS 100000
`define SRP_PROG_TIME_NS 20000

`endif

// *** rtl/srp_pkg.sv ***
// Types shared by the security-register command logic.
// Assumes nothing of its surroundings.
package srp_pkg;

  typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_STATUS, ST_IGNORE} srp_state_type;

  // One byte to be programmed into a security register
  typedef struct packed {
    logic [1:0] bank;
    logic [7:0] ptr;
    logic [7:0] data;
  } srp_wr_type;

endpackage

// *** rtl/srp_buf2.sv ***
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module srp_buf2 #(
  parameter int W = 18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] ent_r [2];
  logic [1:0] cnt_r;
  logic wr_r;
  logic rd_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = ent_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 2'h0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      if (push)
        wr_r <= ~wr_r;
      if (pop)
        rd_r <= ~rd_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      ent_r[wr_r] <= in_data;
  end

endmodule // srp_buf2

`default_nettype wire

// *** tb/srp_host_model.sv ***
// Behavioural SPI host that frames commands for the security-register logic.
// Assumes each task call starts just after a falling edge of clk.
`timescale 1ns/10ps
`default_nettype none

module srp_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  logic active = 1'b0;
  logic rx_stb = 1'b0;
  logic [7:0] rx_byte = 8'h00;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // Idle data line flips every cycle so no stale bit passes for data
  always @(negedge clk)
    if (!active)
      sdi <= ~sdi;

  // ----------------------------------------
  // One frame; half sets the serial clock speed
  // ----------------------------------------
  task automatic xfer(input logic [7:0] b[$], input int nbits, input int half, input bit rd);
    int i;
    active = 1'b1;
    @(negedge clk);
    cs_n = 1'b0;
    for (i = 0; i < nbits; i++)
    begin
      sdi = b[i / 8][7 - i % 8];
      repeat (half) @(negedge clk);
      rx_byte = {rx_byte[6:0], sdo};
      sclk = 1'b1;
      repeat (half) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (half) @(negedge clk);
    cs_n = 1'b1;
    sdi = ~sdi;
    rx_stb = rd;
    @(negedge clk);
    rx_stb = 1'b0;
    repeat (2) @(negedge clk);
    active = 1'b0;
  endtask
endmodule // srp_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the security-register erase/program logic.
// Assumes the host model in its own file and the design's constants header.
`timescale 1ns/10ps
`default_nettype none
`include "srp_defs.svh"

module tb_top;
  localparam int ERA = 400;
  localparam int PRG = 12;
  logic clock = 1'b0;
  logic reset, cs_n, sclk, sdi, sdo, busy, write_enable_latch, look_req, look;
  logic [2:0] lock_set, locks;
  logic [9:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] d[3];
  logic [23:0] bad[4] = '{24'h011000, 24'h001100, 24'h004000, 24'h000000};
  logic [31:0] mem_q[$], st_q[$], busy_q[$];
  int bcnt, num_errors, checked, seed, b, i;

  srp_top #(.ERASE_CYCLES(ERA), .PROG_CYCLES(PRG)) srp_top_i (.CLOCK(clock), .RESET(reset),
    .CS_N(cs_n), .SCLK(sclk), .SERIAL_DATA_IN(sdi), .LOCK_SET(lock_set), .MEM_RD_ADDR(rd_addr),
    .SERIAL_DATA_OUT(sdo), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .SECURITY_LOCK_BITS(locks),
    .MEM_RD_DATA(rd_data));
  srp_host_model srp_host_model_i (.clk(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  always #5 clock = ~clock;

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Results are matched against the oldest note of their own kind
  always @(posedge clock)
  begin
    if (look)
      chk("mem", {24'h0, rd_data}, mem_q.size() ? mem_q.pop_front() : 32'h100);
    look <= look_req;
    if (srp_host_model_i.rx_stb)
      chk("status", {24'h0, srp_host_model_i.rx_byte},
        st_q.size() ? st_q.pop_front() : 32'h100);
    if (busy === 1'b1)
      bcnt <= bcnt + 1;
    else if (bcnt != 0)
    begin
      // A busy spell nobody asked for finds no note and fails
      chk("busy", {bcnt[30:0], write_enable_latch}, busy_q.size() ? busy_q.pop_front() : 32'hffffffff);
      bcnt <= 0;
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic cmd(input logic [7:0] q[$], input int half = 3);
    srp_host_model_i.xfer(q, q.size() * 8, half, 1'b0);
  endtask

  task automatic status(input logic [7:0] op, input logic [7:0] exp);
    st_q.push_back({24'h0, exp});
    srp_host_model_i.xfer({op, 8'h00}, 16, 3, 1'b1);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(negedge clock);
    rd_addr = a;
    look_req = 1'b1;
    mem_q.push_back({24'h0, exp});
    @(negedge clock);
    look_req = 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 5000)
      chk("idle", 32'h0, 32'h1);
    repeat (2) @(negedge clock);
  endtask

  initial
  begin
    repeat (50000) @(posedge clock);
    chk("watchdog", 32'h0, 32'h1);
    end_of_test();
  end

  initial
  begin
    reset = 1'b1;
    lock_set = 3'h0;
    rd_addr = 10'h000;
    look_req = 1'b0;
    seed = 32'h23d6bc66;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    status(`SRP_OP_RDSR1, 8'h00);
    status(`SRP_OP_RDSR2, 8'h00);
    cmd({`SRP_OP_ERASE, 8'h00, 8'h10, 8'h00});
    status(`SRP_OP_RDSR1, 8'h00);
    $display("test reset and no latch done");
    for (b = 1; b <= 3; b++)
    begin
      cmd({`SRP_OP_WREN});
      status(`SRP_OP_RDSR1, 8'h02);
      cmd({`SRP_OP_ERASE, 8'h00, 8'(b << 4), 8'($random(seed))});
      busy_q.push_back(32'(ERA * 2));
      status(`SRP_OP_RDSR1, 8'h03);
      cmd({`SRP_OP_ERASE, 8'h00, 8'(((b % 3) + 1) << 4), 8'h00});
      wait_idle();
      status(`SRP_OP_RDSR1, 8'h00);
    end
    for (b = 0; b < 3; b++)
      for (i = 0; i < `SRP_BANK_BYTES; i++)
        rd({2'(b), 8'(i)}, `SRP_ERASED);
    $display("test erase done");
    for (i = 0; i < 4; i++)
    begin
      cmd({`SRP_OP_WREN});
      cmd({`SRP_OP_ERASE, bad[i][23:16], bad[i][15:8], bad[i][7:0]});
    end
    cmd({`SRP_OP_WREN});
    srp_host_model_i.xfer({`SRP_OP_ERASE, 8'h00, 8'h10, 8'h00, 8'h00}, 40, 3, 1'b0);
    srp_host_model_i.xfer({`SRP_OP_ERASE, 8'h00, 8'h10, 8'h00}, 31, 3, 1'b0);
    cmd({`SRP_OP_WRDI});
    status(`SRP_OP_RDSR1, 8'h00);
    $display("test refused erase done");
    for (i = 0; i < 3; i++)
      d[i] = 8'($random(seed));
    cmd({`SRP_OP_WREN});
    // Note first: the program cycle starts before the frame task returns
    busy_q.push_back(32'(PRG * 2));
    // Offsets FE, FF then wrap to 00, all erased beforehand
    cmd({`SRP_OP_PROG, 8'h00, 8'h20, 8'hfe, d[0], d[1], d[2]}, 6);
    wait_idle();
    rd({2'h1, 8'hfe}, d[0]);
    rd({2'h1, 8'hff}, d[1]);
    rd({2'h1, 8'h00}, d[2]);
    rd({2'h0, 8'hfe}, `SRP_ERASED);
    rd({2'h2, 8'h00}, `SRP_ERASED);
    cmd({`SRP_OP_PROG, 8'h00, 8'h20, 8'h01, 8'h00});
    repeat (10) @(negedge clock);
    rd({2'h1, 8'h01}, `SRP_ERASED);
    $display("test program done");
    @(negedge clock);
    lock_set = 3'h1;
    @(negedge clock);
    lock_set = 3'h0;
    status(`SRP_OP_RDSR2, 8'h08);
    chk("locks", {29'h0, locks}, 32'h1);
    cmd({`SRP_OP_WREN});
    cmd({`SRP_OP_ERASE, 8'h00, 8'h10, 8'h00});
    // Refused erase never runs a cycle, so the latch stays set
    chk("latch", {31'h0, write_enable_latch}, 32'h1);
    cmd({`SRP_OP_WREN});
    cmd({`SRP_OP_PROG, 8'h00, 8'h10, 8'h05, 8'h00});
    repeat (10) @(negedge clock);
    rd({2'h0, 8'h05}, `SRP_ERASED);
    status(`SRP_OP_RDSR2, 8'h08);
    cmd({`SRP_OP_WRDI});
    chk("locks", {29'h0, locks}, 32'h1);
    $display("test lock done");
    repeat (5) @(negedge clock);
    chk("pending", 32'(mem_q.size() + st_q.size() + busy_q.size()), 32'h0);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
